// *** rtl/bridge_adc_serial_port.sv ***
`timescale 1ns/1ps
module bridge_adc_serial_port
	import bridge_adc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	input wire logic clock_polarity_select_i,
	output logic dout_o,
	output logic dout_oe_o,
	output logic rdy_n_o,
	input wire logic [23:0] result_i,
	input wire logic result_valid_i,
	output logic [15:0] mode_o,
	output logic mode_wr_o,
	output logic conv_cont_o,
	output logic cread_o
);
	// link clock: input sampled on its rising edge, output shifted on its falling edge
	logic lclk;
	assign lclk = sclk_i ~^ clock_polarity_select_i;
	// link domain: serial state, registers and output shifter
	port_state_t state, next_state;
	logic [4:0] cnt, next_cnt;
	logic [4:0] top, next_top;
	logic [7:0] in_shift, next_in_shift;
	logic [23:0] wr_shift, next_wr_shift;
	logic [23:0] rd_word, next_rd_word;
	logic [2:0] rs, next_rs;
	logic [23:0] regs [8];
	logic [23:0] next_regs [8];
	logic mode_tog, next_mode_tog;
	logic read_tog, next_read_tog;
	logic rdy_meta, rdy_sync, cread_q;
	logic dout_q;
	logic [7:0] in_byte;
	comm_t comm;
	logic [23:0] data_q;
	logic rdy_n;
	assign in_byte = {in_shift[6:0], din_i};
	assign comm = comm_t'(in_byte);
	// serial state machine, next values
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_top = top;
		next_in_shift = in_shift;
		next_wr_shift = wr_shift;
		next_rd_word = rd_word;
		next_rs = rs;
		next_regs = regs;
		next_mode_tog = mode_tog;
		next_read_tog = read_tog;
		if (!cs_n_i)
		begin
			next_in_shift = in_byte;
			next_wr_shift = {wr_shift[22:0], din_i};
			next_cnt = cnt - 5'h01;
			unique case (state)
				ST_CMD:
					if (cnt == 5'h00)
					begin
						// decode at once so the next clock already belongs to the operation
						next_rs = comm.rs;
						next_top = top_of(comm.rs);
						next_cnt = top_of(comm.rs);
						next_wr_shift = REG_RESET;
						unique case (comm.rw)
							RW_WRITE: next_state = ST_WRITE;
							RW_READ:
							begin
								next_state = ST_READ;
								unique case (comm.rs)
									RS_STATUS: next_rd_word = {16'h0000, rdy_sync, 7'h00};
									RS_DATA: next_rd_word = data_q;
									default: next_rd_word = regs[comm.rs];
								endcase
							end
							RW_CREAD:
							begin
								next_state = ST_CREAD;
								next_top = TOP_24;
								next_cnt = TOP_24;
								next_rd_word = data_q;
							end
							RW_CSTOP: next_cnt = TOP_8; // all-ones filler stays here
						endcase
					end
				ST_WRITE:
					if (cnt == 5'h00)
					begin
						next_regs[rs] = {wr_shift[22:0], din_i};
						if (rs == RS_MODE)
							next_mode_tog = ~mode_tog;
						next_state = ST_CMD;
						next_cnt = TOP_8;
					end
				ST_READ:
					if (cnt == 5'h00)
					begin
						if (rs == RS_DATA)
							next_read_tog = ~read_tog;
						next_state = ST_CMD;
						next_cnt = TOP_8;
					end
				ST_CREAD:
				begin
					if (cnt == TOP_24)
						next_rd_word = data_q; // latest result at the first clock of a word
					if (cnt == 5'h00)
					begin
						next_read_tog = ~read_tog;
						next_cnt = TOP_24;
					end
					// input bytes are checked at each byte boundary of the stream
					if (cnt[2:0] == 3'h0 && in_byte == CMD_CREAD_END)
					begin
						next_state = ST_CMD;
						next_cnt = TOP_8;
					end
				end
			endcase
		end
	end
	// serial state registers
	always_ff @(posedge lclk or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_CMD;
			cnt <= TOP_8;
			top <= TOP_8;
			in_shift <= 8'h00;
			wr_shift <= REG_RESET;
			rd_word <= REG_RESET;
			rs <= RS_STATUS;
			for (int i = 0; i < 8; i++)
				regs[i] <= REG_RESET;
			mode_tog <= 1'b0;
			read_tog <= 1'b0;
			rdy_meta <= 1'b1;
			rdy_sync <= 1'b1;
			cread_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			top <= next_top;
			in_shift <= next_in_shift;
			wr_shift <= next_wr_shift;
			rd_word <= next_rd_word;
			rs <= next_rs;
			regs <= next_regs;
			mode_tog <= next_mode_tog;
			read_tog <= next_read_tog;
			rdy_meta <= rdy_n;
			rdy_sync <= rdy_meta;
			cread_q <= next_state == ST_CREAD; // registered so the crossing sees no glitch
		end
	end
	// output bit launched on the shifting edge
	always_ff @(negedge lclk or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dout_q <= 1'b0;
		else
			dout_q <= rd_word[cnt];
	end
	// msb stands before any clock of the word; a stream shows the latest result
	assign dout_o = (cnt != top) ? dout_q : (state == ST_CREAD) ? data_q[23] : rd_word[cnt];
	assign dout_oe_o = !cs_n_i && (state == ST_READ || state == ST_CREAD);
	// core domain: data register, ready flag and crossings from the link
	logic [23:0] hold_q, next_hold;
	logic [23:0] next_data;
	logic next_rdy_n;
	logic pend_q, next_pend;
	logic [2:0] mode_sy, read_sy;
	logic [1:0] cread_sy;
	logic mode_ev, read_ev;
	logic [15:0] next_mode;
	assign mode_ev = mode_sy[2] ^ mode_sy[1];
	assign read_ev = read_sy[2] ^ read_sy[1];
	assign next_mode = regs[RS_MODE][15:0];
	// data register and ready flag
	always_comb
	begin
		next_rdy_n = rdy_n;
		next_data = data_q;
		next_hold = hold_q;
		next_pend = 1'b0;
		if (read_ev)
			next_rdy_n = 1'b1;
		if (result_valid_i)
		begin
			next_rdy_n = 1'b1; // high just before the update
			next_hold = result_i;
			next_pend = 1'b1;
		end
		else if (pend_q)
		begin
			next_data = hold_q;
			next_rdy_n = 1'b0; // new word wins over a finishing read
		end
	end
	// core registers and crossings from the link
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdy_n <= 1'b1;
			data_q <= REG_RESET;
			hold_q <= REG_RESET;
			pend_q <= 1'b0;
			mode_sy <= 3'h0;
			read_sy <= 3'h0;
			cread_sy <= 2'h0;
			mode_o <= 16'h0000;
			mode_wr_o <= 1'b0;
			conv_cont_o <= 1'b0;
		end
		else
		begin
			rdy_n <= next_rdy_n;
			data_q <= next_data;
			hold_q <= next_hold;
			pend_q <= next_pend;
			mode_sy <= {mode_sy[1:0], mode_tog};
			read_sy <= {read_sy[1:0], read_tog};
			cread_sy <= {cread_sy[0], cread_q};
			mode_wr_o <= mode_ev;
			if (mode_ev)
			begin
				mode_o <= next_mode;
				conv_cont_o <= next_mode[MODE_SEL_HI:MODE_SEL_LO] == MODE_SEL_CONT;
			end
		end
	end
	assign rdy_n_o = rdy_n;
	assign cread_o = cread_sy[1];
	// checks on the link and core behaviour
	a_rdy_pre_update: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		result_valid_i |=> rdy_n_o) else $error("ready not high before update");
	a_rdy_new_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		result_valid_i ##1 !result_valid_i |=> !rdy_n_o) else $error("ready not low on update");
	a_mode_conv_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(conv_cont_o) |-> mode_wr_o) else $error("conversion without mode write");
	a_mode_write_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_wr_o |=> !mode_wr_o) else $error("mode write strobe too long");
	a_half_duplex: assert property (@(posedge lclk) disable iff (!rst_n_i)
		state == ST_WRITE |-> !dout_oe_o) else $error("output driven during write");
	a_write_returns: assert property (@(posedge lclk) disable iff (!rst_n_i)
		state == ST_WRITE && !cs_n_i && cnt == 5'h00 |=> state == ST_CMD && cnt == TOP_8)
		else $error("write did not return to command");
	a_cread_entry: assert property (@(posedge lclk) disable iff (!rst_n_i)
		state == ST_CMD && !cs_n_i && cnt == 5'h00 && in_byte == CMD_CREAD
		|=> state == ST_CREAD && cnt == TOP_24) else $error("continuous read not entered");
	a_cread_exit: assert property (@(posedge lclk) disable iff (!rst_n_i)
		state == ST_CREAD && !cs_n_i && cnt[2:0] == 3'h0 && in_byte == CMD_CREAD_END
		|=> state == ST_CMD) else $error("continuous read not left");
	a_mode_width: assert property (@(posedge lclk) disable iff (!rst_n_i)
		state == ST_CMD && !cs_n_i && cnt == 5'h00 && in_byte == CMD_MODE_WR
		|=> state == ST_WRITE && cnt == TOP_16) else $error("mode write width wrong");
	c_mode_cont: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_wr_o && mode_o == MODE_CONT_WORD);
	c_cread_on: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(cread_o));
	c_cread_off: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(cread_o));
	c_data_read: cover property (@(posedge clk_i) disable iff (!rst_n_i) read_ev && !rdy_n_o);
endmodule : bridge_adc_serial_port

// *** shared/bridge_adc_pkg.sv ***
package bridge_adc_pkg;
	// command bytes and the continuous mode word seen on the serial input
	localparam logic [7:0] CMD_MODE_WR = 8'h02;
	localparam logic [7:0] CMD_CREAD = 8'h21;
	localparam logic [7:0] CMD_CREAD_END = 8'h30;
	localparam logic [15:0] MODE_CONT_WORD = 16'h2180;
	// register selects
	localparam logic [2:0] RS_STATUS = 3'h0;
	localparam logic [2:0] RS_DATA = 3'h1;
	localparam logic [2:0] RS_MODE = 3'h2;
	localparam logic [2:0] RS_FILTER = 3'h3;
	localparam logic [2:0] RS_DAC = 3'h4;
	// read/write field codes
	localparam logic [1:0] RW_WRITE = 2'h0;
	localparam logic [1:0] RW_READ = 2'h1;
	localparam logic [1:0] RW_CREAD = 2'h2;
	localparam logic [1:0] RW_CSTOP = 2'h3;
	// last bit index of each register width
	localparam logic [4:0] TOP_8 = 5'h07;
	localparam logic [4:0] TOP_16 = 5'h0f;
	localparam logic [4:0] TOP_24 = 5'h17;
	// field positions
	localparam int STATUS_RDY_BIT = 7;
	localparam int MODE_SEL_HI = 15;
	localparam int MODE_SEL_LO = 13;
	localparam logic [2:0] MODE_SEL_CONT = 3'h1;
	localparam logic [23:0] REG_RESET = 24'h000000;

	// communications byte layout, msb first
	typedef struct packed {
		logic wen_n;
		logic zero6;
		logic [1:0] rw;
		logic zero3;
		logic [2:0] rs;
	} comm_t;

	// gray codes along cmd -> write -> read -> cread
	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b11,
		ST_CREAD = 2'b10
	} port_state_t;

	// width of the selected register as its top bit index
	function automatic logic [4:0] top_of(input logic [2:0] rs);
		unique case (rs)
			RS_STATUS, RS_DAC: top_of = TOP_8;
			RS_MODE: top_of = TOP_16;
			default: top_of = TOP_24;
		endcase
	endfunction : top_of
endpackage : bridge_adc_pkg

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
	input wire logic pol_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i,
	input wire logic dout_oe_i
);
	// separate data wires, so continuous read can always be left
	// clock idles high to match the polarity strap tied high at start
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// one framed transfer, msb first, clock still outside the frame
	task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r,
		output logic oe_seen);
		r = 32'h00000000;
		oe_seen = 1'b0;
		sclk_o = pol_i; // idle level follows the strap
		#7;
		cs_n_o = 1'b0;
		#24;
		for (int i = 0; i < n; i++)
		begin
			sclk_o = ~pol_i; // shifting edge
			din_o = w[n - 1 - i];
			#24;
			r = {r[30:0], dout_i};
			oe_seen = oe_seen | dout_oe_i;
			sclk_o = pol_i; // active edge, device takes din
			#24;
		end
		cs_n_o = 1'b1;
		din_o = ~din_o; // released line shows the inverse of its last bit
		#24;
	endtask : xfer
endmodule : host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	import bridge_adc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [23:0] result_i = 24'h000000;
	logic result_valid_i = 1'b0;
	logic sclk, cs_n, din, dout_o, dout_oe_o, rdy_n_o, mode_wr_o, conv_cont_o, cread_o;
	logic clock_polarity_select = 1'b1; // polarity strap, changed only under reset
	logic [15:0] mode_o;
	logic [31:0] rd;
	logic oe;
	int err_count = 0;
	int total_checks = 0;
	int wr_pulses = 0;
	// core clock and mode write pulse counter
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (mode_wr_o === 1'b1) wr_pulses <= wr_pulses + 1;
	host_model i_host_model (.pol_i(clock_polarity_select), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_o),
		.dout_oe_i(dout_oe_o));
	bridge_adc_serial_port i_bridge_adc_serial_port (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .clock_polarity_select_i(clock_polarity_select),
		.dout_o(dout_o), .dout_oe_o(dout_oe_o), .rdy_n_o(rdy_n_o), .result_i(result_i),
		.result_valid_i(result_valid_i), .mode_o(mode_o), .mode_wr_o(mode_wr_o),
		.conv_cont_o(conv_cont_o), .cread_o(cread_o));
	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	// let the link to core crossing land
	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask : settle
	task automatic wait_rdy(input logic lvl);
		int n;
		for (n = 0; n < 200 && rdy_n_o !== lvl; n++)
			@(negedge clk_i);
		if (n == 200)
		begin
			err_count++;
			report_and_stop();
		end
	endtask : wait_rdy
	task automatic post(input logic [23:0] v);
		@(posedge clk_i);
		result_i <= v;
		result_valid_i <= 1'b1;
		@(posedge clk_i);
		result_valid_i <= 1'b0;
	endtask : post
	task automatic test_end(input string name);
		$display("test %s done, mismatches %0d", name, err_count);
	endtask : test_end
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({rdy_n_o, cread_o, conv_cont_o, mode_wr_o, mode_o}, {4'h8, 16'h0000});
		i_host_model.xfer(16, 32'h00001000, rd, oe);
		chk(rd[7:0], 8'h80);
		chk(oe, 1'b1);
		test_end("reset_status");
		i_host_model.xfer(32, {CMD_MODE_WR, MODE_CONT_WORD, 8'hff}, rd, oe);
		settle();
		chk(oe, 1'b0);
		chk({conv_cont_o, mode_o}, {1'b1, MODE_CONT_WORD});
		chk(wr_pulses, 1);
		test_end("mode_write");
		post(24'ha5c3f1);
		wait_rdy(1'b0);
		i_host_model.xfer(16, 32'h00001000, rd, oe);
		chk(rd[7:0], 8'h00);
		i_host_model.xfer(32, 32'h11000000, rd, oe);
		chk(rd[23:0], 24'ha5c3f1);
		wait_rdy(1'b1);
		test_end("data_read");
		i_host_model.xfer(8, CMD_CREAD, rd, oe);
		settle();
		chk(cread_o, 1'b1);
		post(24'h123456);
		wait_rdy(1'b0);
		i_host_model.xfer(24, 32'h00000000, rd, oe);
		chk(rd[23:0], 24'h123456);
		i_host_model.xfer(8, CMD_CREAD_END, rd, oe);
		chk(rd[7:0], 8'h12);
		chk(oe, 1'b1);
		settle();
		chk(cread_o, 1'b0);
		i_host_model.xfer(24, {8'h00, CMD_MODE_WR, 16'h0180}, rd, oe);
		settle();
		chk({conv_cont_o, mode_o}, {1'b0, 16'h0180});
		chk(wr_pulses, 2);
		test_end("continuous_read");
		// second reset in mid-run, then accesses with the clock idling low
		rst_n_i <= 1'b0;
		clock_polarity_select <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({rdy_n_o, cread_o, conv_cont_o, mode_wr_o, mode_o}, {4'h8, 16'h0000});
		i_host_model.xfer(16, 32'h00001000, rd, oe);
		chk(rd[7:0], 8'h80);
		post(24'h3c96e1);
		wait_rdy(1'b0);
		i_host_model.xfer(32, 32'h11000000, rd, oe);
		chk(rd[23:0], 24'h3c96e1);
		test_end("low_idle_clock");
		report_and_stop();
	end
endmodule : tb
